// >>> design/ascr_pkg.sv
package ascr_pkg;
	// Register offsets on the register port.
	localparam logic [5:0] ASCR_ADDR_THR_POS = 6'h10;
	localparam logic [5:0] ASCR_ADDR_THR_NEG = 6'h12;
	localparam logic [5:0] ASCR_ADDR_STATUS = 6'h14;
	localparam logic [5:0] ASCR_ADDR_TICK = 6'h15;
	localparam logic [5:0] ASCR_ADDR_CORR = 6'h16;
	localparam logic [5:0] ASCR_ADDR_RSVD_1C = 6'h1c;
	localparam logic [5:0] ASCR_ADDR_RSVD_1D = 6'h1d;
	// Reset values.
	localparam logic [7:0] ASCR_THR_RESET = 8'h00;
	localparam logic [7:0] ASCR_TICK_RESET = 8'h00;
	localparam logic [7:0] ASCR_CORR_RESET = 8'h00;
	localparam logic [7:0] ASCR_ZERO_BYTE = 8'h00;
	// Status field positions.
	localparam int ASCR_ST_IDE = 6;
	localparam int ASCR_ST_INIT = 4;
	localparam int ASCR_ST_MISO = 3;
	localparam int ASCR_ST_ZERO = 2;
	localparam int ASCR_ST_OFFS = 1;
	localparam int ASCR_ST_RES = 0;
	// CRC generator x^3+x+1 and all-ones seed.
	localparam logic [2:0] ASCR_CRC_POLY = 3'h3;
	localparam logic [2:0] ASCR_CRC_SEED = 3'h7;
	localparam int ASCR_CRC_DATA_W = 16;
	// Tick timing: one count every 128 us on a 100 ns clock.
	localparam int ASCR_CLK_PERIOD_NS = 100;
	localparam int ASCR_TICK_PERIOD_US = 128;
	localparam int ASCR_TICK_CYCLES = (ASCR_TICK_PERIOD_US * 1000) / ASCR_CLK_PERIOD_NS;
	localparam logic [10:0] ASCR_TICK_LAST = 11'(ASCR_TICK_CYCLES - 1);
	localparam logic [10:0] ASCR_PRESC_ZERO = 11'h000;
	localparam logic [7:0] ASCR_TICK_ONE = 8'h01;
endpackage : ascr_pkg

// >>> design/ascr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module ascr_regs
	import ascr_pkg::*;
(
	// Clock and reset.
	input wire logic i_core_clk,
	input wire logic i_rst,
	// Register port.
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [5:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	// Device control and fault events from the core.
	input wire logic i_init_complete_lock,
	input wire logic i_init_done,
	input wire logic i_miso_mismatch,
	input wire logic i_offset_limit,
	input wire logic i_other_fault,
	// Offset cancellation update.
	input wire logic i_corr_valid,
	input wire logic [7:0] i_corr_value,
	// OTP shadow array image and its stored CRC.
	input wire logic [15:0] i_otp_image,
	input wire logic [2:0] i_otp_crc,
	// Arming configuration outputs.
	output logic [7:0] o_positive_threshold_field,
	output logic [7:0] o_negative_threshold_field,
	output logic o_arm_pos_enable,
	output logic o_arm_neg_enable,
	output logic o_arm_enable,
	// Status level outputs.
	output logic o_internal_data_error_flag
);

	// Serial 3-bit CRC over a 16-bit image, MSB first, all-ones seed.
	function automatic logic [2:0] ascr_crc3(input logic [15:0] data);
		logic [2:0] crc;
		logic fb;
		crc = ASCR_CRC_SEED;
		for (int i = ASCR_CRC_DATA_W - 1; i >= 0; i--) begin
			fb = crc[2] ^ data[i];
			crc = {crc[1:0], 1'b0} ^ (fb ? ASCR_CRC_POLY : 3'h0);
		end
		return crc;
	endfunction

	// Stored registers.
	logic [7:0] thr_pos_r; // Positive threshold.
	logic [7:0] thr_neg_r; // Negative threshold.
	logic [7:0] tick_r; // Oscillator tick value.
	logic [10:0] presc_r; // Tick prescaler.
	logic [7:0] corr_r; // Latest applied correction.
	logic [7:0] rdata_r; // Read data.
	logic ide_r; // Internal data error flag.
	logic init_r; // Init in progress flag.
	logic miso_r; // Output mismatch flag.
	logic offs_r; // Offset limit flag.
	logic res_r; // Reset occurred flag.
	logic lock_d_r; // Lock delayed one cycle.
	logic [2:0] wcrc_ref_r; // Writable CRC reference taken at lock.
	logic wcrc_fault_r; // Writable CRC fault, held until reset.
	logic pos_en_r; // Positive comparisons enabled.
	logic neg_en_r; // Negative comparisons enabled.
	logic arm_en_r; // Arming function enabled.

	// Decoding.
	wire sel_pos = (i_reg_addr == ASCR_ADDR_THR_POS);
	wire sel_neg = (i_reg_addr == ASCR_ADDR_THR_NEG);
	wire sel_status = (i_reg_addr == ASCR_ADDR_STATUS);
	wire wr_open = i_reg_wr && !i_init_complete_lock;
	wire wr_pos = wr_open && sel_pos;
	wire wr_neg = wr_open && sel_neg;
	wire rd_status = i_reg_rd && sel_status;
	wire [15:0] wr_image = {thr_pos_r, thr_neg_r};
	wire [2:0] wr_crc = ascr_crc3(wr_image);
	wire wcrc_check = i_init_complete_lock && lock_d_r;
	wire wcrc_bad = wcrc_check && (wr_crc != wcrc_ref_r);
	wire otp_bad = (ascr_crc3(i_otp_image) != i_otp_crc);
	wire ide_set = otp_bad || wcrc_bad || wcrc_fault_r || i_other_fault;
	wire tick_wrap = (presc_r == ASCR_TICK_LAST);
	wire pos_nz = (thr_pos_r != ASCR_ZERO_BYTE);
	wire neg_nz = (thr_neg_r != ASCR_ZERO_BYTE);

	// Status byte; bits 7 and 5 read zero, bit 2 is a constant zero.
	logic [7:0] status_val;
	always_comb begin
		status_val = ASCR_ZERO_BYTE;
		status_val[ASCR_ST_IDE] = ide_r;
		status_val[ASCR_ST_INIT] = init_r;
		status_val[ASCR_ST_MISO] = miso_r;
		status_val[ASCR_ST_ZERO] = 1'b0;
		status_val[ASCR_ST_OFFS] = offs_r;
		status_val[ASCR_ST_RES] = res_r;
	end

	// Read mux; reserved and unmapped locations read as zero.
	logic [7:0] rd_mux;
	always_comb begin
		unique case (i_reg_addr)
			ASCR_ADDR_THR_POS: rd_mux = thr_pos_r;
			ASCR_ADDR_THR_NEG: rd_mux = thr_neg_r;
			ASCR_ADDR_STATUS: rd_mux = status_val;
			ASCR_ADDR_TICK: rd_mux = tick_r;
			ASCR_ADDR_CORR: rd_mux = corr_r;
			default: rd_mux = ASCR_ZERO_BYTE;
		endcase
	end

	// Threshold storage; writes after lock are dropped.
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			thr_pos_r <= ASCR_THR_RESET;
			thr_neg_r <= ASCR_THR_RESET;
		end else begin
			if (wr_pos) begin
				thr_pos_r <= i_reg_wdata;
			end
			if (wr_neg) begin
				thr_neg_r <= i_reg_wdata;
			end
		end
	end

	// Read data register, loaded on every read strobe.
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			rdata_r <= ASCR_ZERO_BYTE;
		end else if (i_reg_rd) begin
			rdata_r <= rd_mux;
		end
	end

	// Free-running tick counter behind a prescaler.
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			presc_r <= ASCR_PRESC_ZERO;
			tick_r <= ASCR_TICK_RESET;
		end else begin
			presc_r <= tick_wrap ? ASCR_PRESC_ZERO : presc_r + 11'h001;
			if (tick_wrap) begin
				tick_r <= tick_r + ASCR_TICK_ONE;
			end
		end
	end

	// Latest correction from offset cancellation.
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			corr_r <= ASCR_CORR_RESET;
		end else if (i_corr_valid) begin
			corr_r <= i_corr_value;
		end
	end

	// Writable CRC reference is taken when the lock rises; a fault sticks.
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			lock_d_r <= 1'b0;
			wcrc_ref_r <= ASCR_CRC_SEED;
			wcrc_fault_r <= 1'b0;
		end else begin
			lock_d_r <= i_init_complete_lock;
			if (i_init_complete_lock && !lock_d_r) begin
				wcrc_ref_r <= wr_crc;
			end
			if (wcrc_bad) begin
				wcrc_fault_r <= 1'b1;
			end
		end
	end

	// Status flags; a set in the clearing cycle wins over the clear.
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			ide_r <= 1'b0;
			init_r <= 1'b1;
			miso_r <= 1'b0;
			offs_r <= 1'b0;
			res_r <= 1'b1;
		end else begin
			ide_r <= ide_set || (ide_r && !rd_status);
			if (i_init_done) begin
				init_r <= 1'b0;
			end
			miso_r <= i_miso_mismatch || (miso_r && !rd_status);
			offs_r <= i_offset_limit || (offs_r && !rd_status);
			res_r <= init_r || (res_r && !rd_status);
		end
	end

	// Arming enables derived from the thresholds.
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			pos_en_r <= 1'b0;
			neg_en_r <= 1'b0;
			arm_en_r <= 1'b0;
		end else begin
			pos_en_r <= pos_nz;
			neg_en_r <= neg_nz;
			arm_en_r <= pos_nz || neg_nz;
		end
	end

	// Outputs straight from flip-flops.
	assign o_reg_rdata = rdata_r;
	assign o_positive_threshold_field = thr_pos_r;
	assign o_negative_threshold_field = thr_neg_r;
	assign o_arm_pos_enable = pos_en_r;
	assign o_arm_neg_enable = neg_en_r;
	assign o_arm_enable = arm_en_r;
	assign o_internal_data_error_flag = ide_r;

	// Locked thresholds never change.
	AST_LOCK_HOLDS: assert property (@(posedge i_core_clk) disable iff (i_rst)
		$past(i_init_complete_lock) |-> $stable(thr_pos_r) && $stable(thr_neg_r))
		else $error("Threshold changed while locked.");

	// An open write lands next cycle.
	AST_WRITE_LANDS: assert property (@(posedge i_core_clk) disable iff (i_rst)
		wr_pos |=> thr_pos_r == $past(i_reg_wdata))
		else $error("Positive threshold write lost.");

	// Both thresholds zero keeps arming off.
	AST_BOTH_ZERO: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!pos_nz && !neg_nz |=> !o_arm_enable && !o_arm_pos_enable && !o_arm_neg_enable)
		else $error("Arming enabled with both thresholds zero.");

	// A zero positive threshold disables only the positive polarity.
	AST_ONE_ZERO: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!pos_nz && neg_nz |=> o_arm_enable && !o_arm_pos_enable && o_arm_neg_enable)
		else $error("Wrong polarity enable for zero threshold.");

	// Status read returns the flags and clears the transient ones.
	AST_READ_CLEARS: assert property (@(posedge i_core_clk) disable iff (i_rst)
		rd_status && !i_miso_mismatch |=> !miso_r && o_reg_rdata[ASCR_ST_MISO] == $past(miso_r))
		else $error("Mismatch flag not cleared by read.");

	// Init flag is untouched by a status read.
	AST_INIT_KEEP: assert property (@(posedge i_core_clk) disable iff (i_rst)
		init_r && !i_init_done |=> init_r)
		else $error("Init flag cleared early.");

	// OTP CRC mismatch raises the data error flag.
	AST_OTP_IDE: assert property (@(posedge i_core_clk) disable iff (i_rst)
		otp_bad |=> ide_r)
		else $error("OTP CRC error not flagged.");

	// Writable CRC fault keeps re-asserting the flag.
	AST_WCRC_STICKY: assert property (@(posedge i_core_clk) disable iff (i_rst)
		wcrc_bad |=> ide_r ##1 ide_r ##1 ide_r)
		else $error("Writable CRC fault not held.");

	// Tick advances by one at each prescaler wrap.
	AST_TICK_STEP: assert property (@(posedge i_core_clk) disable iff (i_rst)
		tick_wrap |=> tick_r == $past(tick_r) + ASCR_TICK_ONE)
		else $error("Tick counter step wrong.");

	// Between prescaler wraps the tick value stands still.
	AST_TICK_IDLE: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!tick_wrap |=> $stable(tick_r))
		else $error("Tick counter moved between wraps.");

	// A write to a locked threshold leaves the stored value as it was.
	AST_LOCKED_DROP: assert property (@(posedge i_core_clk) disable iff (i_rst)
		i_reg_wr && i_init_complete_lock && sel_pos |=> $stable(thr_pos_r))
		else $error("Locked positive threshold took a write.");

	// A zero negative threshold disables only the negative polarity.
	AST_NEG_ZERO: assert property (@(posedge i_core_clk) disable iff (i_rst)
		pos_nz && !neg_nz |=> o_arm_enable && o_arm_pos_enable && !o_arm_neg_enable)
		else $error("Wrong polarity enable for zero negative threshold.");

	// A mismatch event sets its flag, even in a clearing read.
	AST_MISO_SETS: assert property (@(posedge i_core_clk) disable iff (i_rst)
		i_miso_mismatch |=> miso_r)
		else $error("Mismatch event lost.");

	// A status read with no new event clears the offset flag.
	AST_OFFS_CLEARS: assert property (@(posedge i_core_clk) disable iff (i_rst)
		rd_status && !i_offset_limit |=> !offs_r)
		else $error("Offset flag not cleared by read.");

	// The data error flag clears on a read once no fault remains.
	AST_IDE_CLEARS: assert property (@(posedge i_core_clk) disable iff (i_rst)
		rd_status && !ide_set |=> !ide_r)
		else $error("Data error flag not cleared by read.");

	// The reset flag stays set until a status read.
	AST_RES_HELD: assert property (@(posedge i_core_clk) disable iff (i_rst)
		res_r && !rd_status |=> res_r)
		else $error("Reset flag dropped without a read.");

endmodule // ascr_regs
`default_nettype wire

// >>> dv/ascr_host.sv
`timescale 1ns/1ps
`default_nettype none
module ascr_host
	import ascr_pkg::*;
(
	// Clock and read data.
	input wire logic i_clk,
	input wire logic [7:0] i_rdata,
	// Register strobes.
	output logic o_wr,
	output logic o_rd,
	output logic [5:0] o_addr,
	output logic [7:0] o_wdata
);
	// Idle bus at time zero.
	initial begin
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_addr = 6'h00;
		o_wdata = 8'h00;
	end
	// One write; reserved places only ever see zeros.
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic rsvd;
		rsvd = (a == ASCR_ADDR_RSVD_1C) || (a == ASCR_ADDR_RSVD_1D);
		@(posedge i_clk);
		o_wr <= 1'b1;
		o_addr <= a;
		o_wdata <= rsvd ? ASCR_ZERO_BYTE : d;
		@(posedge i_clk);
		o_wr <= 1'b0;
	endtask
	// One read; data is taken once the accepting edge has landed.
	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		@(posedge i_clk);
		o_rd <= 1'b1;
		o_addr <= a;
		@(posedge i_clk);
		o_rd <= 1'b0;
		#1;
		d = i_rdata;
	endtask
endmodule // ascr_host
`default_nettype wire

// >>> dv/arming_status_crc_registers_test.sv
`timescale 1ns/1ps
`default_nettype none
module arming_status_crc_registers_test
	import ascr_pkg::*;
;
	logic clk, rst, lock, cv;
	logic [3:0] ev; // Events: done, mismatch, offset, fault.
	logic [7:0] cval, d, p, n, t0;
	logic [15:0] otp;
	logic [2:0] otpc;
	wire logic wr, rd, pe, ne, ae, internal_data_error_flag;
	wire logic [5:0] addr;
	wire logic [7:0] wdata, rdata, pos, neg;
	int error_cnt = 0;
	int checked = 0;
	logic [5:0] rst_addr [7] = '{6'h10, 6'h12, 6'h15, 6'h16, 6'h1c, 6'h1d, 6'h20};
	always #50 clk = ~clk;
	ascr_host u_ascr_host (.i_clk(clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd),
		.o_addr(addr), .o_wdata(wdata));
	ascr_regs u_ascr_regs (.i_core_clk(clk), .i_rst(rst), .i_reg_wr(wr), .i_reg_rd(rd),
		.i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
		.i_init_complete_lock(lock), .i_init_done(ev[0]), .i_miso_mismatch(ev[1]),
		.i_offset_limit(ev[2]), .i_other_fault(ev[3]), .i_corr_valid(cv),
		.i_corr_value(cval), .i_otp_image(otp), .i_otp_crc(otpc),
		.o_positive_threshold_field(pos), .o_negative_threshold_field(neg),
		.o_arm_pos_enable(pe), .o_arm_neg_enable(ne), .o_arm_enable(ae),
		.o_internal_data_error_flag(internal_data_error_flag));
	// Reference CRC, serial MSB first, generator x^3+x+1, seed all ones.
	function automatic logic [2:0] crc3(input logic [15:0] v);
		logic [2:0] c;
		c = 3'h7;
		for (int i = 15; i >= 0; i--) begin
			c = {c[1:0], 1'b0} ^ ((c[2] ^ v[i]) ? 3'h3 : 3'h0);
		end
		return c;
	endfunction
	// Compares one value and counts the result.
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Raises the chosen event lines for one cycle.
	task automatic pulse(input logic [3:0] v);
		@(posedge clk);
		ev <= v;
		@(posedge clk);
		ev <= 4'h0;
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic close_out();
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Cuts a hang short.
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		close_out();
	end
	// Main sequence.
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		lock = 1'b0;
		ev = 4'h0;
		cv = 1'b0;
		cval = 8'h00;
		void'($urandom(32'hc338));
		otp = 16'($urandom());
		otpc = crc3(otp);
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		foreach (rst_addr[i]) begin
			u_ascr_host.rd(rst_addr[i], d);
			chk("reset value", d, 8'h00);
		end
		u_ascr_host.rd(ASCR_ADDR_STATUS, d);
		chk("status in init", d, 8'h11);
		pulse(4'h1);
		u_ascr_host.rd(ASCR_ADDR_STATUS, d);
		chk("status after init", d, 8'h01);
		u_ascr_host.rd(ASCR_ADDR_STATUS, d);
		chk("status cleared", d, 8'h00);
		for (int k = 0; k < 4; k++) begin
			p = k[0] ? 8'($urandom_range(255, 1)) : 8'h00;
			n = k[1] ? 8'($urandom_range(255, 1)) : 8'h00;
			u_ascr_host.wr(ASCR_ADDR_THR_POS, p);
			u_ascr_host.wr(ASCR_ADDR_THR_NEG, n);
			@(posedge clk);
			#1;
			chk("pos field", pos, p);
			chk("neg field", neg, n);
			chk("enables", {5'h0, pe, ne, ae}, {5'h0, p != 0, n != 0, (p | n) != 0});
		end
		pulse(4'he);
		#1;
		chk("error flag set", {7'h0, internal_data_error_flag}, 8'h01);
		u_ascr_host.rd(ASCR_ADDR_STATUS, d);
		chk("status events", d, 8'h4a);
		chk("error flag read", {7'h0, internal_data_error_flag}, 8'h00);
		u_ascr_host.rd(ASCR_ADDR_STATUS, d);
		chk("events cleared", d, 8'h00);
		@(posedge clk);
		cval <= 8'($urandom());
		cv <= 1'b1;
		@(posedge clk);
		cv <= 1'b0;
		u_ascr_host.rd(ASCR_ADDR_CORR, d);
		chk("correction", d, cval);
		@(posedge clk);
		lock <= 1'b1;
		u_ascr_host.wr(ASCR_ADDR_THR_POS, ~p);
		u_ascr_host.wr(ASCR_ADDR_THR_NEG, ~n);
		u_ascr_host.wr(ASCR_ADDR_RSVD_1C, 8'hff);
		u_ascr_host.rd(ASCR_ADDR_THR_POS, d);
		chk("locked pos", d, p);
		u_ascr_host.rd(ASCR_ADDR_THR_NEG, d);
		chk("locked neg", d, n);
		u_ascr_host.rd(ASCR_ADDR_STATUS, d);
		chk("locked status", d, 8'h00);
		u_ascr_host.rd(ASCR_ADDR_TICK, t0);
		repeat (3 * ASCR_TICK_CYCLES - 2) @(posedge clk);
		u_ascr_host.rd(ASCR_ADDR_TICK, d);
		chk("tick advance", d, t0 + 8'h03);
		@(posedge clk);
		otpc <= ~otpc;
		u_ascr_host.rd(ASCR_ADDR_STATUS, d);
		chk("otp fault", d, 8'h40);
		u_ascr_host.rd(ASCR_ADDR_STATUS, d);
		chk("otp fault again", d, 8'h40);
		// A reset in mid-run must not hide a fuse array fault.
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		u_ascr_host.rd(ASCR_ADDR_STATUS, d);
		chk("fuse fault after reset", d, 8'h51);
		chk("error flag after reset", {7'h0, internal_data_error_flag}, 8'h01);
		u_ascr_host.rd(ASCR_ADDR_THR_POS, d);
		chk("pos after reset", d, 8'h00);
		close_out();
	end
endmodule // arming_status_crc_registers_test
`default_nettype wire
